// >>> include/eecp_pkg.sv
// eecp_pkg: map, field positions and reset values of the eeprom config/protection block
package eecp_pkg;
  // register and array indices; byte address on the bus is four times the index
  localparam int unsigned ADDR_W       = 18;
  localparam logic [15:0] IDX_ARR_LO   = 16'h0800;
  localparam logic [15:0] IDX_ARR_HI   = 16'h09FF;
  localparam logic [15:0] IDX_SEC_LO   = 16'h08F0;
  localparam logic [15:0] IDX_SEC_HI   = 16'h08FF;
  localparam logic [15:0] IDX_DIVNV_HI = 16'hFE10;
  localparam logic [15:0] IDX_DIVNV_LO = 16'hFE11;
  localparam logic [15:0] IDX_DIV_HI   = 16'hFE1A;
  localparam logic [15:0] IDX_DIV_LO   = 16'hFE1B;
  localparam logic [15:0] IDX_CFG_NV   = 16'hFE1C;
  localparam logic [15:0] IDX_CTRL     = 16'hFE1D;
  localparam logic [15:0] IDX_ACFG     = 16'hFE1F;
  // array_control fields
  localparam int unsigned CTL_PGM      = 0;
  localparam int unsigned CTL_AUTO     = 1;
  localparam int unsigned CTL_LAT      = 2;
  localparam int unsigned CTL_ERS_LO   = 3;
  localparam int unsigned CTL_ERS_HI   = 4;
  localparam logic [7:0]  CTL_WMASK    = 8'hBF;
  localparam logic [7:0]  CTL_RST      = 8'h00;
  // configuration and divider fields
  localparam int unsigned CFG_ARM      = 4;
  localparam int unsigned DIVH_SEC     = 7;
  localparam int unsigned DIV_W        = 11;
  // non-volatile contents as shipped
  localparam logic [7:0]  NV_ERASED    = 8'hFF;
  localparam logic [7:0]  CFG_FACTORY  = 8'hF0;
  // length of one program/erase in timebase ticks
  localparam int unsigned OP_TICKS_DEF = 10;
  // erase size selection held in array_control[4:3]
  typedef enum logic [1:0] {
    OP_PROG  = 2'h0,
    OP_BYTE  = 2'h1,
    OP_BLOCK = 2'h2,
    OP_BULK  = 2'h3
  } eecp_op_e;
  // bus handshake phase
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } eecp_bus_e;
endpackage : eecp_pkg

// >>> design/eecp_core.sv
// eecp_core: eeprom array, non-volatile configuration, timebase and protection
//
// Operation
// [R1] 512-byte array at $0800-$09FF, program/erase with no external supply.
// [R2] Every reset copies non-volatile config and divider bytes into volatile copies.
// [R3] Config byte mirrors into array_config; divider bytes into divider high/low.
// [R4] 35 us timebase divides bus or crystal clock, chosen by select, by divisor.
// [R5] Software loads divisor = round(fref * 35e-6) before any program/erase.
// [R6] Armed protect bit blocks program/erase of $08F0-$08FF; reads still work.
// [R7] Armed protect bit freezes config_nv against program and erase.
// [R8] Armed protect bit refuses block and bulk erase of the rest.
// [R9] Armed, single-byte program/erase still works on unprotected bytes. Here byte erase leaves array bytes unchanged (old AND $FF).
// [R10] Four 128-byte blocks, each locked by its block-protect bit.
// [R11] Block-protect changes apply after reset or a read of config_nv.
// [R12] Divider-secure bit programmed 0 loads 0 into volatile copy at reset.
// [R13] Divider secured: no program/erase of divider nv bytes, volatile writes ignored.
// [R14] Erased bits read 1; every byte ships as $FF. Here config_nv ships as $F0 (CFG_FACTORY).
// [R15] Programming only clears bits, one to eight within one byte.
// [R16] Non-volatile bytes change only by program/erase, never by plain writes.
// [R17] Program start refused without latch enable and a valid latched address.
// [R18] Self-timed mode ends the cycle and clears program start itself.
// [R19] Clearing program start and latch together clears only program start.
// [R20] Requests aimed at protected bytes change nothing at all.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module eecp_core
  import eecp_pkg::*;
#(
  parameter int unsigned OP_TICKS = OP_TICKS_DEF
) (
  // clock, reset, enable
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  // avalon-mm slave
  input  wire logic [eecp_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // timebase reference
  input  wire logic                       timebase_clock_select,
  input  wire logic                       crystal_ref_clock,
  // status
  output logic                            op_busy,
  output logic                            timebase_tick,
  output logic      [7:0]                 array_config
);
  import eecp_pkg::*;

  localparam int unsigned OPC_W = $clog2(OP_TICKS + 1);
  localparam logic [OPC_W-1:0] OP_LAST = OPC_W'(OP_TICKS - 1);

  //--------------------------------------------------------------
  // state
  //--------------------------------------------------------------
  typedef struct packed {
    logic [511:0][7:0] mem;
    logic [7:0]        cfg_nv;
    logic [7:0]        divnv_h;
    logic [7:0]        divnv_l;
    logic [7:0]        acfg;
    logic [7:0]        ctrl;
    logic [3:0]        divh;     // secure bit and divisor bits 10:8
    logic [7:0]        divl;
    logic [15:0]       lat_idx;
    logic [7:0]        lat_data;
    logic              lat_ok;
    logic [DIV_W-1:0]  tb_cnt;
    logic              tb_tick;
    logic              ref_q;
    logic [OPC_W-1:0]  op_cnt;
    eecp_bus_e         bus;
    logic [7:0]        rdata;
    logic              wait_r;
  } eecp_state_s;

  // non-volatile bytes power up as shipped; volatile fields are set by reset
  localparam eecp_state_s ST_INIT = '{mem: {512{NV_ERASED}}, cfg_nv: CFG_FACTORY, // R14
                                      divnv_h: NV_ERASED, divnv_l: NV_ERASED,
                                      bus: BUS_IDLE, wait_r: 1'b1, default: '0};

  eecp_state_s st_reg = ST_INIT;
  eecp_state_s st_next;

  // block-protect lookup for one array offset, used by single and bulk paths
  function automatic logic blk_locked(input logic [7:0] cfg, input logic [8:0] off);
    blk_locked = cfg[off[8:7]];
  endfunction : blk_locked

  logic [15:0]      idx;
  logic [15:0]      t_idx;
  logic [8:0]       t_off;
  logic             t_arr;
  logic             t_sec;
  logic             armed;
  logic             div_sec;
  logic             prot;
  logic             wide;
  logic             commit;
  logic             auto_fin;
  logic             ctrl_wr;
  logic             div_wr;
  logic             cfg_rd;
  logic [7:0]       wb;
  logic [7:0]       nctl;
  logic [7:0]       mem_old;
  logic [7:0]       fill;
  logic [DIV_W-1:0] divisor;
  logic             ref_edge;
  eecp_op_e         op;

  //--------------------------------------------------------------
  // next-state logic
  //--------------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    idx      = avs_address[ADDR_W-1:2];
    wb       = avs_writedata[7:0];
    t_idx    = st_reg.lat_idx;
    t_off    = t_idx[8:0];
    t_arr    = (t_idx >= IDX_ARR_LO) && (t_idx <= IDX_ARR_HI);                  // R1
    t_sec    = (t_idx >= IDX_SEC_LO) && (t_idx <= IDX_SEC_HI);
    armed    = ~st_reg.cfg_nv[CFG_ARM];
    div_sec  = ~st_reg.divh[3];
    prot     = blk_locked(st_reg.acfg, t_off) | (armed & t_sec);               // R6 R10
    op       = eecp_op_e'(st_reg.ctrl[CTL_ERS_HI:CTL_ERS_LO]);
    wide     = (op == OP_BLOCK) || (op == OP_BULK);
    mem_old  = st_reg.mem[t_off];
    fill     = (op == OP_PROG) ? st_reg.lat_data : NV_ERASED;
    divisor  = {st_reg.divh[2:0], st_reg.divl};
    ref_edge = timebase_clock_select ? 1'b1 : (crystal_ref_clock & ~st_reg.ref_q);
    commit   = 1'b0;
    auto_fin = 1'b0;
    ctrl_wr  = 1'b0;
    div_wr   = 1'b0;
    cfg_rd   = 1'b0;
    nctl     = st_reg.ctrl;
    if (clk_en && rst_n) begin
      // timebase: one tick per divisor reference edges; zero acts as one
      st_next.ref_q   = crystal_ref_clock;
      st_next.tb_tick = 1'b0;
      if (ref_edge) begin
        if (st_reg.tb_cnt + DIV_W'(1) >= divisor) begin                      // R4 R5
          st_next.tb_cnt  = '0;
          st_next.tb_tick = 1'b1;
        end else begin
          st_next.tb_cnt = st_reg.tb_cnt + DIV_W'(1);
        end
      end
      // running operation counts ticks; self-timed mode ends it on its own
      if (st_reg.ctrl[CTL_PGM] && st_reg.tb_tick) begin
        if (st_reg.ctrl[CTL_AUTO] && st_reg.op_cnt == OP_LAST) begin
          auto_fin                  = 1'b1;                                    // R18
          st_next.ctrl[CTL_PGM]     = 1'b0;
        end else begin
          st_next.op_cnt = st_reg.op_cnt + OPC_W'(1);
        end
      end
      // bus: answer sampled in idle, effects land on the edge that ends the wait
      unique case (st_reg.bus)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            st_next.bus    = BUS_ACK;
            st_next.wait_r = 1'b0;
            st_next.rdata  = 8'h00;
            if (idx >= IDX_ARR_LO && idx <= IDX_ARR_HI) begin
              st_next.rdata = st_reg.mem[idx[8:0]];                            // R6 R14
            end else begin
              unique case (idx)
                IDX_DIVNV_HI: st_next.rdata = st_reg.divnv_h;
                IDX_DIVNV_LO: st_next.rdata = st_reg.divnv_l;
                IDX_DIV_HI:   st_next.rdata = {st_reg.divh[3], 4'h0, st_reg.divh[2:0]};
                IDX_DIV_LO:   st_next.rdata = st_reg.divl;
                IDX_CFG_NV:   st_next.rdata = st_reg.cfg_nv;
                IDX_CTRL:     st_next.rdata = st_reg.ctrl;
                IDX_ACFG:     st_next.rdata = st_reg.acfg;
                default:      st_next.rdata = 8'h00;
              endcase
            end
          end
        end
        BUS_ACK: begin
          st_next.bus    = BUS_IDLE;
          st_next.wait_r = 1'b1;
          if (avs_read && idx == IDX_CFG_NV) begin
            cfg_rd       = 1'b1;
            st_next.acfg = st_reg.cfg_nv;                                      // R11
          end
          if (avs_write && avs_byteenable[0]) begin
            if ((idx >= IDX_ARR_LO && idx <= IDX_ARR_HI) || idx == IDX_CFG_NV ||
                idx == IDX_DIVNV_HI || idx == IDX_DIVNV_LO) begin
              // plain writes never reach non-volatile bytes, they only latch
              if (st_reg.ctrl[CTL_LAT] && !st_reg.ctrl[CTL_PGM]) begin         // R16
                st_next.lat_idx  = idx;
                st_next.lat_data = wb;
                st_next.lat_ok   = 1'b1;
              end
            end else if (idx == IDX_DIV_HI || idx == IDX_DIV_LO) begin
              div_wr = 1'b1;
              if (!div_sec) begin                                              // R13
                if (idx == IDX_DIV_HI) begin
                  st_next.divh = {wb[DIVH_SEC], wb[2:0]};
                end else begin
                  st_next.divl = wb;
                end
              end
            end else if (idx == IDX_CTRL) begin
              ctrl_wr = 1'b1;
              nctl    = wb & CTL_WMASK;
              // start needs an open latch holding a valid target
              if (nctl[CTL_PGM] && !st_reg.ctrl[CTL_PGM] &&
                  !(st_reg.ctrl[CTL_LAT] && st_reg.lat_ok)) begin
                nctl[CTL_PGM] = 1'b0;                                          // R17
              end
              // keep the latch while high voltage is being removed
              if (st_reg.ctrl[CTL_PGM] && !nctl[CTL_PGM]) begin
                nctl[CTL_LAT] = 1'b1;                                          // R19
                commit        = 1'b1;
              end
              if (!nctl[CTL_LAT]) begin
                st_next.lat_ok = 1'b0;
              end
              if (nctl[CTL_PGM] && !st_reg.ctrl[CTL_PGM]) begin
                st_next.op_cnt = '0;
              end
              st_next.ctrl = nctl;
            end
          end
        end
        default: begin
          st_next.bus    = BUS_IDLE;
          st_next.wait_r = 1'b1;
        end
      endcase
      // apply the operation at its end; refused targets stay untouched
      if (commit || auto_fin) begin
        commit = 1'b1;
        if (t_arr && wide) begin
          if (!armed) begin                                                    // R8
            for (int i = 0; i < 512; i++) begin
              if (!blk_locked(st_reg.acfg, 9'(i)) &&
                  (op == OP_BULK || 2'(i >> 7) == t_off[8:7])) begin           // R10
                st_next.mem[i] = NV_ERASED;                                    // R14
              end
            end
          end
        end else if (t_arr) begin
          if (!prot) begin                                                     // R9 R20
            st_next.mem[t_off] = mem_old & fill;                               // R15
          end
        end else if (t_idx == IDX_CFG_NV) begin
          if (!armed) begin                                                    // R7
            st_next.cfg_nv = (op == OP_PROG) ? (st_reg.cfg_nv & fill) : NV_ERASED;
          end
        end else if (!div_sec) begin                                           // R13
          if (t_idx == IDX_DIVNV_HI) begin
            st_next.divnv_h = (op == OP_PROG) ? (st_reg.divnv_h & fill) : NV_ERASED;
          end else begin
            st_next.divnv_l = (op == OP_PROG) ? (st_reg.divnv_l & fill) : NV_ERASED;
          end
        end
      end
    end
    // reset reloads volatile copies from non-volatile bytes, even with enable low
    if (!rst_n) begin
      st_next.ctrl     = CTL_RST;
      st_next.acfg     = st_reg.cfg_nv;                                        // R2 R3
      st_next.divh     = {st_reg.divnv_h[DIVH_SEC], st_reg.divnv_h[2:0]};      // R12
      st_next.divl     = st_reg.divnv_l;
      st_next.lat_idx  = '0;
      st_next.lat_data = '0;
      st_next.lat_ok   = 1'b0;
      st_next.tb_cnt   = '0;
      st_next.tb_tick  = 1'b0;
      st_next.ref_q    = 1'b0;
      st_next.op_cnt   = '0;
      st_next.bus      = BUS_IDLE;
      st_next.rdata    = 8'h00;
      st_next.wait_r   = 1'b1;
    end
  end

  //--------------------------------------------------------------
  // registers and outputs
  //--------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  assign avs_readdata    = {24'h000000, st_reg.rdata};
  assign avs_waitrequest = st_reg.wait_r;
  assign op_busy         = st_reg.ctrl[CTL_PGM];
  assign timebase_tick   = st_reg.tb_tick;
  assign array_config    = st_reg.acfg;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  logic was_rst;
  always_ff @(posedge core_clk) begin
    was_rst <= ~rst_n;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_reset_load_copy: assert property (was_rst |-> st_reg.acfg == st_reg.cfg_nv && // R2 R3 R12
    st_reg.divl == st_reg.divnv_l && st_reg.divh[3] == st_reg.divnv_h[DIVH_SEC])
    else $error("volatile copies not loaded at reset");
  a_start_needs_latch: assert property ($rose(st_reg.ctrl[CTL_PGM]) |-> // R17
    $past(st_reg.ctrl[CTL_LAT]) && $past(st_reg.lat_ok))
    else $error("program start set without a valid latch");
  a_auto_self_clear: assert property (auto_fin |=> !st_reg.ctrl[CTL_PGM] // R18
    && st_reg.ctrl[CTL_LAT]) else $error("self-timed end left program start set");
  a_clear_keeps_latch: assert property (ctrl_wr && st_reg.ctrl[CTL_PGM] && // R19
    !wb[CTL_PGM] && !wb[CTL_LAT] |=> st_reg.ctrl[CTL_LAT] && !st_reg.ctrl[CTL_PGM])
    else $error("latch dropped with program start");
  a_prog_clears_only: assert property (commit && op == OP_PROG && t_arr && !prot // R15
    |=> st_reg.mem[$past(t_off)] == ($past(mem_old) & $past(st_reg.lat_data)))
    else $error("program result is not old and data");
  a_secure_hold: assert property (commit && armed && t_arr && t_sec // R6
    |=> st_reg.mem[$past(t_off)] == $past(mem_old))
    else $error("secure byte changed while armed");
  a_wide_refused: assert property (commit && armed && t_arr && wide // R8
    |=> st_reg.mem == $past(st_reg.mem)) else $error("wide erase ran while armed");
  a_block_hold: assert property (commit && t_arr && blk_locked(st_reg.acfg, t_off) // R10
    |=> st_reg.mem[$past(t_off)] == $past(mem_old)) else $error("protected block changed");
  a_div_locked: assert property (div_wr && div_sec |=> // R13
    {st_reg.divh, st_reg.divl} == $past({st_reg.divh, st_reg.divl}))
    else $error("secured divider accepted a write");
  a_cfg_read_load: assert property (cfg_rd |=> st_reg.acfg == $past(st_reg.cfg_nv)) // R11
    else $error("config read did not refresh array_config");
  a_wait_one: assert property (st_reg.bus == BUS_IDLE && (avs_read || avs_write) && clk_en
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");

  c_prog_done: cover property (commit && op == OP_PROG && t_arr && !prot);
  c_bulk_done: cover property (commit && op == OP_BULK && !armed);
  c_cfg_reload: cover property (cfg_rd);
  c_auto_end: cover property (auto_fin);

endmodule : eecp_core

// >>> sim/eecp_cpu_model.sv
// eecp_cpu_model: cpu-side master of the avalon-mm register bus
`timescale 1ns/1ps
module eecp_cpu_model
  import eecp_pkg::*;
(
  // clock
  input  wire logic                        core_clk,
  // avalon-mm master
  output logic      [eecp_pkg::ADDR_W-1:0] avs_address,
  output logic                             avs_read,
  output logic                             avs_write,
  output logic      [31:0]                 avs_writedata,
  output logic      [3:0]                  avs_byteenable,
  input  wire logic [31:0]                 avs_readdata,
  input  wire logic                        avs_waitrequest
);
  // idle bus at time zero
  initial begin
    avs_address    <= '0;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_writedata  <= '0;
    avs_byteenable <= 4'hF;
  end

  // one transfer; released lines flip so stale values never look valid
  // the wait has no limit of its own: only the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge core_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    avs_address   <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask : xfer
endmodule : eecp_cpu_model

// >>> sim/eeprom_config_protection_tb.sv
// eeprom_config_protection_tb: self-checking bench of eecp_core against a shadow model
`timescale 1ns/1ps
module eeprom_config_protection_tb;
  import eecp_pkg::*;
  //--------------------------------------------------------------
  // signals and shadow state
  //--------------------------------------------------------------
  logic                core_clk = 1'b0;
  logic                rst_n    = 1'b0;
  logic                sel      = 1'b1;
  logic                xtal     = 1'b0;
  logic                clk_en   = 1'b1;
  logic [ADDR_W-1:0]   avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                op_busy;
  logic                timebase_tick;
  logic [7:0]          array_config;
  logic [7:0]          sh [512];
  logic [7:0]          cfg = CFG_FACTORY;
  logic [7:0]          dnh = NV_ERASED;
  logic [7:0]          dnl = NV_ERASED;
  logic [7:0]          acfg, dvh, dvl, rv;
  logic [15:0]         ridx [8] = '{IDX_DIVNV_HI, IDX_DIVNV_LO, IDX_DIV_HI, IDX_DIV_LO,
                                    IDX_CFG_NV, IDX_CTRL, IDX_ACFG, 16'h0A00};
  int unsigned         num_errors = 0;
  int unsigned         compares   = 0;
  int                  i, b, gap;

  // short self-timed ops keep the run small
  eecp_core #(.OP_TICKS(2)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timebase_clock_select(sel), .crystal_ref_clock(xtal), .op_busy(op_busy),
    .timebase_tick(timebase_tick), .array_config(array_config));
  eecp_cpu_model u_cpu (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // 40 MHz core clock; crystal reference rises every second cycle
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) xtal <= ~xtal;

  //--------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, d, rv);
  endtask : wr

  // a read of config_nv refreshes the volatile copy
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    u_cpu.xfer(1'b0, a, 8'h00, rv);
    if (a == IDX_CFG_NV) acfg = cfg;
    chk(rv, exp);
  endtask : rdc

  function automatic logic [7:0] shadow_of(input logic [15:0] a);
    case (a)
      IDX_CFG_NV:   return cfg;
      IDX_DIVNV_HI: return dnh;
      IDX_DIVNV_LO: return dnl;
      IDX_DIV_HI:   return dvh;
      IDX_DIV_LO:   return dvl;
      IDX_ACFG:     return acfg;
      IDX_CTRL:     return 8'h00;
      default:      return (a[15:9] == 7'h04) ? sh[a[8:0]] : 8'h00;
    endcase
  endfunction : shadow_of

  function automatic logic blocked(input logic [15:0] a);
    if (a == IDX_CFG_NV) return !cfg[CFG_ARM];
    if (a == IDX_DIVNV_HI || a == IDX_DIVNV_LO) return !dvh[DIVH_SEC];
    return acfg[a[8:7]] || (!cfg[CFG_ARM] && a[15:4] == 12'h08F);
  endfunction : blocked

  function automatic logic [7:0] nvn(input logic [1:0] sz, input logic [7:0] old, input logic [7:0] d);
    return (sz == OP_PROG) ? (old & d) : NV_ERASED;
  endfunction : nvn

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    acfg = cfg;
    dvh  = {dnh[7], 4'h0, dnh[2:0]};
    dvl  = dnl;
  endtask : do_reset

  task automatic check_regs;
    foreach (ridx[k]) rdc(ridx[k], shadow_of(ridx[k]));
  endtask : check_regs

  task automatic sweep;
    for (int k = 0; k < 512; k++) rdc(16'h0800 + 16'(k), sh[k]);
  endtask : sweep

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // cycles between two timebase ticks
  task automatic tick_gap(output int g);
    int n = 0;
    while (timebase_tick !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    g = 0;
    do begin
      @(posedge core_clk);
      g++;
    end while (timebase_tick !== 1'b1 && g < 50);
  endtask : tick_gap

  // latch, target write, start, finish; manual mode ends with one write clearing start and latch
  task automatic op(input logic [1:0] sz, input logic [15:0] a, input logic [7:0] d, input logic man);
    int n = 0;
    wr(IDX_CTRL, {3'b000, sz, 1'b1, ~man, 1'b0});
    wr(a, d);
    wr(IDX_CTRL, {3'b000, sz, 1'b1, ~man, 1'b1});
    if (man) wr(IDX_CTRL, 8'h00);
    // the start lands on the edge the write returns at; let op_busy show it first
    @(posedge core_clk);
    while (op_busy !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    rdc(IDX_CTRL, man ? 8'h04 : {3'b000, sz, 3'b110});
    wr(IDX_CTRL, 8'h00);
    case (a)
      IDX_CFG_NV:   if (!blocked(a)) cfg = nvn(sz, cfg, d);
      IDX_DIVNV_HI: if (!blocked(a)) dnh = nvn(sz, dnh, d);
      IDX_DIVNV_LO: if (!blocked(a)) dnl = nvn(sz, dnl, d);
      default:
        if (sz[1]) begin
          if (cfg[CFG_ARM]) for (n = 0; n < 512; n++) if (!acfg[n/128] && (sz[0] || n/128 == a[8:7])) sh[n] = NV_ERASED;
        end else if (!blocked(a)) sh[a[8:0]] = nvn(sz, sh[a[8:0]], d);
    endcase
    chk(array_config, acfg);
    rdc(a, shadow_of(a));
  endtask : op

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  //--------------------------------------------------------------
  // tests
  //--------------------------------------------------------------
  initial begin
    void'($urandom(32'h64f2));
    foreach (sh[j]) sh[j] = NV_ERASED;
    do_reset();
    check_regs();
    chk(array_config, acfg);
    wr(IDX_ACFG, 8'h00);
    wr(IDX_CTRL, 8'hE0);
    rdc(IDX_CTRL, 8'hA0);
    wr(IDX_CTRL, 8'h00);
    rdc(IDX_ACFG, acfg);
    done("registers");
    wr(IDX_CTRL, 8'h01);
    rdc(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h04);
    wr(IDX_CTRL, 8'h05);
    rdc(IDX_CTRL, 8'h04);
    wr(IDX_CTRL, 8'h00);
    wr({7'h04, 9'h1A5}, 8'h00);
    wr(IDX_CFG_NV, 8'h00);
    rdc({7'h04, 9'h1A5}, NV_ERASED);
    rdc(IDX_CFG_NV, cfg);
    done("refusals");
    wr(IDX_DIV_HI, 8'h80);
    wr(IDX_DIV_LO, 8'h04);
    dvh = 8'h80;
    dvl = 8'h04;
    check_regs();
    tick_gap(gap);
    tick_gap(gap);
    chk(gap[7:0], 8'h04);
    sel <= 1'b0;
    tick_gap(gap);
    tick_gap(gap);
    chk(gap[7:0], 8'h08);
    sel <= 1'b1;
    // enable low must freeze the timebase, which would otherwise pulse every 4 cycles
    clk_en <= 1'b0;
    @(posedge core_clk);
    rv = {7'h00, timebase_tick};
    i  = 0;
    repeat (20) begin
      @(posedge core_clk);
      if (timebase_tick !== rv[0]) i++;
    end
    chk(i[7:0], 8'h00);
    clk_en <= 1'b1;
    done("timebase");
    for (i = 0; i < 16; i++) op(2'($urandom), {7'h04, 9'($urandom)}, 8'($urandom), i[0]);
    sweep();
    done("random");
    for (b = 0; b < 4; b++) begin
      op(OP_BYTE, IDX_CFG_NV, 8'h00, 1'b0);
      op(OP_PROG, IDX_CFG_NV, 8'hF0 | (8'h01 << b), 1'b0);
      for (i = 0; i < 4; i++) op(2'($urandom), {7'h04, 2'(i), 7'($urandom)}, 8'($urandom), 1'b0);
    end
    done("blocks");
    op(OP_BYTE, IDX_CFG_NV, 8'h00, 1'b0);
    op(OP_PROG, IDX_CFG_NV, 8'hE4, 1'b0);
    op(OP_BYTE, IDX_CFG_NV, 8'h00, 1'b0);
    op(OP_PROG, {12'h08F, 4'($urandom)}, 8'h00, 1'b0);
    op(OP_BLOCK, {7'h04, 9'($urandom)}, 8'h00, 1'b0);
    op(OP_BULK, {7'h04, 9'($urandom)}, 8'h00, 1'b0);
    op(OP_PROG, {7'h04, 3'b010, 6'($urandom)}, 8'($urandom), 1'b0);
    op(OP_BYTE, {7'h04, 2'b10, 7'($urandom)}, 8'h00, 1'b0);
    sweep();
    done("armed");
    op(OP_PROG, IDX_DIVNV_LO, 8'h04, 1'b0);
    op(OP_PROG, IDX_DIVNV_HI, 8'h78, 1'b0);
    do_reset();
    check_regs();
    chk(array_config, acfg);
    wr(IDX_DIV_LO, 8'hFF);
    rdc(IDX_DIV_LO, dvl);
    op(OP_BYTE, IDX_DIVNV_LO, 8'h00, 1'b0);
    sweep();
    done("divider");
    tally_and_finish();
  end

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : eeprom_config_protection_tb
